// [hw/sltx_char_if.sv]
// Character hand-off from the byte-slot logic to the serialiser.
`timescale 1ns/10ps
`default_nettype none
interface sltx_char_if;
  sltx_pkg::sltx_char_t word;
  logic                 load;
  modport source (output word, output load);
  modport sink   (input word, input load);
endinterface : sltx_char_if
`default_nettype wire

// [hw/sltx_pin_sync.sv]
// Three-stage pin synchroniser with a second/third stage agreement filter.
`timescale 1ns/10ps
`default_nettype none
`include "sltx_regs.svh"
module sltx_pin_sync (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic [`SLTX_SYNC_WIDTH-1:0] pinIn,
  output logic      [`SLTX_SYNC_WIDTH-1:0] stable
);
  logic [`SLTX_SYNC_WIDTH-1:0] stage1_reg;
  logic [`SLTX_SYNC_WIDTH-1:0] stage2_reg;
  logic [`SLTX_SYNC_WIDTH-1:0] stage3_reg;
  logic [`SLTX_SYNC_WIDTH-1:0] stable_reg;
  logic [`SLTX_SYNC_WIDTH-1:0] agree;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit only changes once two successive samples show the same level.
  assign agree = ~(stage2_reg ^ stage3_reg);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stable_reg <= '0;
    end else begin
      stable_reg <= (agree & stage3_reg) | (~agree & stable_reg);
    end
  end

  assign stable = stable_reg;
endmodule : sltx_pin_sync
`default_nettype wire

// [hw/sltx_pkg.sv]
// Types shared by the serial link transmit front end.
package sltx_pkg;
  typedef enum logic [1:0] {
    SLTX_MODE_ENC  = 2'h0,
    SLTX_MODE_RAW  = 2'h1,
    SLTX_MODE_TEST = 2'h3
  } sltx_mode_t;
  typedef logic [9:0] sltx_char_t;
endpackage : sltx_pkg

// [hw/sltx_regs.svh]
// Constants and timing counts of the serial link transmit front end.
`ifndef SLTX_REGS_SVH
`define SLTX_REGS_SVH

`define SLTX_CLK_PERIOD_NS   8
`define SLTX_CHAR_BITS       4'hA
`define SLTX_SYNC_WIDTH      19
`define SLTX_STROBE_LOW_PCT  60
`define SLTX_STROBE_LOW_CYC  4'((10 * `SLTX_STROBE_LOW_PCT) / 100)
`define SLTX_NULL_BYTE       8'hBC
`define SLTX_BUILT_IN_SELF_TEST_LAST       8'hFF
`define SLTX_K28_INDEX       5'h1C
`define SLTX_NULL_CODE_NEG   10'h0FA
`define SLTX_NULL_CODE_POS   10'h305
`define SLTX_ALT_CODE        10'h155
`define SLTX_VIOL_CODE       10'h0F8

`endif

// [hw/sltx_serializer.sv]
// Ten-bit serialiser, first code bit out first.
`timescale 1ns/10ps
`default_nettype none
module sltx_serializer (
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  sltx_char_if.sink  charIn,
  input  wire logic  shiftEn,
  output logic       serialBit
);
  sltx_pkg::sltx_char_t shift_reg;
  logic                 serialBit_reg;
  logic                 wordFirst;
  logic                 wordSecond;

  // Without a fresh load the character repeats, so the line never idles.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shift_reg     <= '0;
      serialBit_reg <= 1'b0;
    end else if (charIn.load) begin
      shift_reg     <= {charIn.word[8:0], charIn.word[9]};
      serialBit_reg <= charIn.word[9];
    end else if (shiftEn) begin
      shift_reg     <= {shift_reg[8:0], shift_reg[9]};
      serialBit_reg <= shift_reg[9];
    end
  end

  assign serialBit  = serialBit_reg;
  assign wordFirst  = charIn.word[9];
  assign wordSecond = charIn.word[8];

  AST_SERIAL_ORDER:
    assert property (@(posedge sys_clk) disable iff (!nrst)
      charIn.load ##1 (!charIn.load && shiftEn) |->
        serialBit == $past(wordFirst) ##1 serialBit == $past(wordSecond, 2))
    else $error("Serial bits do not follow the loaded character order.");
endmodule : sltx_serializer
`default_nettype wire

// [hw/sltx_top.sv]
// Serial link transmit front end: byte slots, line coding, self-test and outputs.
// Summary of operation
// - Byte taken at write edge when load-now low.
// - Both enables high: send fill character.
// - Load-next low: take byte at following edge.
// - Load-next and load-now high: next slot is fill.
// - Special select picks control or data alphabet.
// - Send-violation, except in raw mode, sends violation, ignores data inputs.
// - Violation overrides the self-test generator.
// - Mode low: bytes are 8B/10B encoded.
// - Mode high: ten raw bits bypass encoder.
// - Mode floating: external differential bit clock used.
// - Ten bits shifted per byte on all pairs.
// - Optical off forces pairs one and two low.
// - Loopback pair always carries the stream.
// - Self-test, both enables high: alternating pattern.
// - Self-test, an enable low: repeating test sequence; in raw mode the code sends the ten raw bits instead.
// - Self-test steps only in slots that take a byte; violation restarts its sequence.
// - Self-test enable sampled like the data.
// - Read strobe low 60 percent; in self-test, low one whole slot once per loop.
`timescale 1ns/10ps
`default_nettype none
`include "sltx_regs.svh"
module sltx_top (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       byteWriteClock,
  input  wire logic       loadNowN,
  input  wire logic       loadNextN,
  input  wire logic [7:0] parallelByteIn,
  input  wire logic       specialCharSelect,
  input  wire logic       sendViolation,
  input  wire logic       opticalTxOff,
  input  wire logic       selfTestEnableN,
  input  wire logic       encoderModeRaw,
  input  wire logic       encoderModeFloat,
  input  wire logic       serialPairFirstPIn,
  input  wire logic       serialPairSecondPIn,
  output logic            serialPairFirstP,
  output logic            serialPairFirstPOeN,
  output logic            serialPairFirstN,
  output logic            serialPairSecondP,
  output logic            serialPairSecondPOeN,
  output logic            serialPairSecondN,
  output logic            serialPairLoopbackP,
  output logic            serialPairLoopbackN,
  output logic            fifoReadStrobeN
);
  // Six-bit sub-block for running disparity negative, bit a first.
  function automatic logic [5:0] sixTab(input logic [4:0] x);
    logic [5:0] t;
    unique case (x)
      5'h00: t = 6'b100111;  5'h01: t = 6'b011101;  5'h02: t = 6'b101101;
      5'h03: t = 6'b110001;  5'h04: t = 6'b110101;  5'h05: t = 6'b101001;
      5'h06: t = 6'b011001;  5'h07: t = 6'b111000;  5'h08: t = 6'b111001;
      5'h09: t = 6'b100101;  5'h0A: t = 6'b010101;  5'h0B: t = 6'b110100;
      5'h0C: t = 6'b001101;  5'h0D: t = 6'b101100;  5'h0E: t = 6'b011100;
      5'h0F: t = 6'b010111;  5'h10: t = 6'b011011;  5'h11: t = 6'b100011;
      5'h12: t = 6'b010011;  5'h13: t = 6'b110010;  5'h14: t = 6'b001011;
      5'h15: t = 6'b101010;  5'h16: t = 6'b011010;  5'h17: t = 6'b111010;
      5'h18: t = 6'b110011;  5'h19: t = 6'b100110;  5'h1A: t = 6'b010110;
      5'h1B: t = 6'b110110;  5'h1C: t = 6'b001110;  5'h1D: t = 6'b101110;
      5'h1E: t = 6'b011110;  5'h1F: t = 6'b101011;
    endcase
    return t;
  endfunction : sixTab

  // Four-bit sub-block for running disparity negative, bit f first.
  function automatic logic [3:0] fourTab(input logic [2:0] y);
    logic [3:0] t;
    unique case (y)
      3'h0: t = 4'b1011;  3'h1: t = 4'b1001;  3'h2: t = 4'b0101;  3'h3: t = 4'b1100;
      3'h4: t = 4'b1101;  3'h5: t = 4'b1010;  3'h6: t = 4'b0110;  3'h7: t = 4'b1110;
    endcase
    return t;
  endfunction : fourTab

  // Returns the new disparity (1 = positive) above the ten code bits.
  function automatic logic [10:0] encode(input logic [7:0] b, input logic k,
                                         input logic rdPos);
    logic [5:0] six;
    logic [3:0] four;
    logic       rdMid;
    logic       alt;
    logic       flip4;
    six   = (k && b[4:0] == `SLTX_K28_INDEX) ? 6'b001111 : sixTab(b[4:0]);
    rdMid = ($countones(six) != 3) ? ~rdPos : rdPos;
    if (rdPos && ($countones(six) != 3 || six == 6'b111000)) begin
      six = ~six;
    end
    alt  = (b[7:5] == 3'h7) && (k || (!rdMid && (b[4:0] == 5'h11 || b[4:0] == 5'h12
           || b[4:0] == 5'h14)) || (rdMid && (b[4:0] == 5'h0B || b[4:0] == 5'h0D
           || b[4:0] == 5'h0E)));
    four = alt ? 4'b0111 : fourTab(b[7:5]);
    if ($countones(four) != 2 || four == 4'b1100) begin
      flip4 = rdMid;
    end else begin
      flip4 = k && !rdMid;
    end
    if (flip4) begin
      four = ~four;
    end
    return {($countones(four) != 2) ? ~rdMid : rdMid, six, four};
  endfunction : encode

  // Only K28.y and K23/27/29/30.7 are legal control characters.
  function automatic logic kValid(input logic [7:0] b);
    return (b[4:0] == `SLTX_K28_INDEX) || (b[7:5] == 3'h7 && (b[4:0] == 5'h17
           || b[4:0] == 5'h1B || b[4:0] == 5'h1D || b[4:0] == 5'h1E));
  endfunction : kValid

  logic [`SLTX_SYNC_WIDTH-1:0] pinVec;
  logic [`SLTX_SYNC_WIDTH-1:0] syncVec;
  logic                        sClk;
  logic                        sNowN;
  logic                        sNextN;
  logic                        sSc;
  logic                        sSvs;
  logic                        sOff;
  logic                        sBistN;
  logic                        sModeRaw;
  logic                        sModeFloat;
  logic                        sTa;
  logic                        sTb;
  logic [7:0]                  sByte;
  sltx_pkg::sltx_mode_t        mode;
  logic                        clkPrev_reg;
  logic                        testPrev_reg;
  logic                        byteEdge;
  logic                        testClk;
  logic                        testEdge;
  logic                        shiftEn;
  logic                        pendingLoad_reg;
  logic                        takeByte;
  logic                        bistOn;
  logic                        rawSel;
  logic                        violSel;
  logic                        bistSel;
  logic                        userSel;
  logic [7:0]                  bistCnt_reg;
  logic                        rd_reg;
  logic                        rdNext;
  sltx_pkg::sltx_char_t        charWord_reg;
  sltx_pkg::sltx_char_t        charNext;
  logic                        charLoad_reg;
  sltx_pkg::sltx_char_t        rawWord;
  sltx_pkg::sltx_char_t        dataCode;
  sltx_pkg::sltx_char_t        specCode;
  sltx_pkg::sltx_char_t        nullCode;
  sltx_pkg::sltx_char_t        bistCode;
  logic                        dataRd;
  logic                        specRd;
  logic                        nullRd;
  logic                        bistRd;
  logic                        serBit;
  logic [3:0]                  strobeCnt_reg;
  logic [3:0]                  strobeLen_reg;
  logic                        strobeN_reg;
  logic                        pairFirstP_reg;
  logic                        pairSecondP_reg;
  logic                        pairLoopP_reg;
  logic                        pairOeN_reg;

  sltx_char_if charBus ();

  // Every pin, data included, passes the same filter so the byte and its
  // write edge stay aligned; data must be steady around the write edge.
  assign pinVec = {byteWriteClock, loadNowN, loadNextN, specialCharSelect, sendViolation,
                   opticalTxOff, selfTestEnableN, encoderModeRaw, encoderModeFloat,
                   serialPairFirstPIn, serialPairSecondPIn, parallelByteIn};

  sltx_pin_sync pinSync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pinIn   (pinVec),
    .stable  (syncVec)
  );

  assign {sClk, sNowN, sNextN, sSc, sSvs, sOff, sBistN, sModeRaw, sModeFloat,
          sTa, sTb, sByte} = syncVec;

  always_comb begin
    if (sModeFloat) begin
      mode = sltx_pkg::SLTX_MODE_TEST;
    end else if (sModeRaw) begin
      mode = sltx_pkg::SLTX_MODE_RAW;
    end else begin
      mode = sltx_pkg::SLTX_MODE_ENC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      clkPrev_reg  <= 1'b0;
      testPrev_reg <= 1'b0;
    end else begin
      clkPrev_reg  <= sClk;
      testPrev_reg <= testClk;
    end
  end

  assign byteEdge = sClk && !clkPrev_reg;
  assign testClk  = sTa && !sTb;
  assign testEdge = testClk && !testPrev_reg;
  // The internal bit rate is one bit per system clock; the write clock must
  // therefore run at a tenth of the system clock.
  assign shiftEn  = (mode == sltx_pkg::SLTX_MODE_TEST) ? testEdge : 1'b1;

  assign takeByte = !sNowN || pendingLoad_reg;
  assign bistOn   = !sBistN;
  assign rawSel   = (mode == sltx_pkg::SLTX_MODE_RAW) && takeByte;
  assign violSel  = (mode != sltx_pkg::SLTX_MODE_RAW) && sSvs;
  assign bistSel  = !rawSel && !violSel && bistOn;
  assign userSel  = !rawSel && !violSel && !bistOn && takeByte;

  assign rawWord = {sSc, {<<{sByte}}, sSvs};
  assign {dataRd, dataCode} = encode(sByte, 1'b0, rd_reg);
  assign {specRd, specCode} = encode(sByte, 1'b1, rd_reg);
  assign {nullRd, nullCode} = encode(`SLTX_NULL_BYTE, 1'b1, rd_reg);
  assign {bistRd, bistCode} = encode(bistCnt_reg, 1'b0, rd_reg);

  // Violation and alternating codes are disparity neutral, so the running
  // disparity carries across them unchanged.
  always_comb begin
    charNext = `SLTX_NULL_CODE_NEG;
    rdNext   = rd_reg;
    if (rawSel) begin
      charNext = rawWord;
    end else if (violSel) begin
      charNext = `SLTX_VIOL_CODE;
    end else if (bistSel && takeByte) begin
      charNext = bistCode;
      rdNext   = bistRd;
    end else if (bistSel) begin
      charNext = `SLTX_ALT_CODE;
    end else if (userSel && sSc && kValid(sByte)) begin
      charNext = specCode;
      rdNext   = specRd;
    end else if (userSel && sSc) begin
      charNext = `SLTX_VIOL_CODE;
    end else if (userSel) begin
      charNext = dataCode;
      rdNext   = dataRd;
    end else begin
      charNext = nullCode;
      rdNext   = nullRd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      charWord_reg <= `SLTX_NULL_CODE_NEG;
      rd_reg       <= 1'b0;
      charLoad_reg <= 1'b0;
    end else begin
      charLoad_reg <= byteEdge;
      if (byteEdge) begin
        charWord_reg <= charNext;
        rd_reg       <= rdNext;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pendingLoad_reg <= 1'b0;
    end else if (byteEdge) begin
      pendingLoad_reg <= !sNextN;
    end
  end

  // The sequence is a counting loop of 256 data bytes; it needs no seeding.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bistCnt_reg <= 8'h00;
    end else if (byteEdge && violSel && bistOn) begin
      bistCnt_reg <= 8'h00;
    end else if (byteEdge && bistSel && takeByte) begin
      bistCnt_reg <= bistCnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strobeCnt_reg <= 4'h0;
      strobeLen_reg <= `SLTX_STROBE_LOW_CYC;
      strobeN_reg   <= 1'b1;
    end else if (byteEdge) begin
      strobeCnt_reg <= 4'h0;
      if (bistSel) begin
        strobeN_reg   <= !(takeByte && bistCnt_reg == `SLTX_BUILT_IN_SELF_TEST_LAST);
        strobeLen_reg <= `SLTX_CHAR_BITS;
      end else begin
        strobeN_reg   <= sNowN;
        strobeLen_reg <= `SLTX_STROBE_LOW_CYC;
      end
    end else begin
      if (strobeCnt_reg != 4'hF) begin
        strobeCnt_reg <= strobeCnt_reg + 4'h1;
      end
      if (strobeCnt_reg == strobeLen_reg - 4'h1) begin
        strobeN_reg <= 1'b1;
      end
    end
  end

  assign charBus.word = charWord_reg;
  assign charBus.load = charLoad_reg;

  sltx_serializer serializer (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .charIn    (charBus.sink),
    .shiftEn   (shiftEn),
    .serialBit (serBit)
  );

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pairFirstP_reg  <= 1'b0;
      pairSecondP_reg <= 1'b0;
      pairLoopP_reg   <= 1'b0;
      pairOeN_reg     <= 1'b0;
    end else begin
      pairFirstP_reg  <= !sOff && serBit;
      pairSecondP_reg <= !sOff && serBit;
      pairLoopP_reg   <= serBit;
      pairOeN_reg     <= (mode == sltx_pkg::SLTX_MODE_TEST);
    end
  end

  assign serialPairFirstP     = pairFirstP_reg;
  assign serialPairFirstN     = !pairFirstP_reg;
  assign serialPairFirstPOeN  = pairOeN_reg;
  assign serialPairSecondP    = pairSecondP_reg;
  assign serialPairSecondN    = !pairSecondP_reg;
  assign serialPairSecondPOeN = pairOeN_reg;
  assign serialPairLoopbackP  = pairLoopP_reg;
  assign serialPairLoopbackN  = !pairLoopP_reg;
  assign fifoReadStrobeN      = strobeN_reg;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  AST_LOAD_NOW:
    assert property (byteEdge && userSel && !sNowN && !sSc |=>
      charWord_reg == $past(dataCode) && charLoad_reg)
    else $error("Byte with load-now low was not encoded as data.");

  AST_FILL:
    assert property (byteEdge && mode == sltx_pkg::SLTX_MODE_ENC && !sSvs && !bistOn
      && sNowN && !pendingLoad_reg |=>
      charWord_reg == `SLTX_NULL_CODE_NEG || charWord_reg == `SLTX_NULL_CODE_POS)
    else $error("Idle slot did not carry the fill character.");

  AST_LOAD_NEXT:
    assert property (byteEdge && !sNextN |=> pendingLoad_reg && takeByte)
    else $error("Load-next request was not held for the following edge.");

  AST_VIOLATION:
    assert property (byteEdge && violSel |=> charWord_reg == `SLTX_VIOL_CODE)
    else $error("Send-violation did not produce the violation code.");

  AST_BUILT_IN_SELF_TEST_ALT:
    assert property (byteEdge && bistSel && !takeByte |=> charWord_reg == `SLTX_ALT_CODE)
    else $error("Self-test idle slot did not send the alternating pattern.");

  AST_BUILT_IN_SELF_TEST_RESTART:
    assert property (byteEdge && violSel && bistOn |=> bistCnt_reg == 8'h00)
    else $error("Violation during self-test did not restart the sequence.");

  AST_OPT_OFF:
    assert property (sOff ##1 sOff |-> !serialPairFirstP && serialPairFirstN
      && !serialPairSecondP && serialPairSecondN)
    else $error("Pairs one and two were not held low while optical off.");

  AST_LOOPBACK:
    assert property (##1 1'b1 |-> serialPairLoopbackP == $past(serBit)
      && serialPairLoopbackN != serialPairLoopbackP)
    else $error("Loopback pair does not follow the serial stream.");

  AST_STROBE_LOW:
    assert property (byteEdge && !bistSel && !sNowN |=>
      !fifoReadStrobeN [*6] ##1 fifoReadStrobeN)
    else $error("Read strobe low time is not six cycles.");
endmodule : sltx_top
`default_nettype wire

// [testbench/sltx_host_model.sv]
// Host side model: byte write clock and pin drive for the transmit front end.
`timescale 1ns/10ps
`default_nettype none
module sltx_host_model (
  input  wire logic        sys_clk,
  input  wire logic [12:0] stage,
  output logic             tick,
  output logic             byteWriteClock,
  output logic [12:0]      pins
);
  logic [3:0]  cnt_reg  = 4'h0;
  // Idle levels from time zero, so no unknown value enters the pin filter.
  logic [12:0] pins_reg = 13'h1900;
  // The host owns the byte clock; it runs at exactly a tenth of sys_clk.
  always_ff @(posedge sys_clk) begin
    cnt_reg <= (cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
  end
  assign byteWriteClock = (cnt_reg < 4'h5);
  assign tick = (cnt_reg == 4'h3);
  // Pins move with the falling half, so they are steady five cycles either side of the rise.
  always_ff @(posedge sys_clk) begin
    if (cnt_reg == 4'h4) begin
      pins_reg <= stage;
    end
  end
  assign pins = pins_reg;
endmodule : sltx_host_model
`default_nettype wire

// [testbench/sltx_top_tb.sv]
// Self-checking bench for the serial link transmit front end.
`timescale 1ns/10ps
`default_nettype none
module sltx_top_tb;
  localparam logic [12:0] IDLE = 13'h1900;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        raw = 1'b0;
  logic        flt = 1'b0;
  logic        optical_tx_off = 1'b0;
  logic        fPin = 1'b0;
  logic        sPin = 1'b0;
  logic [12:0] stage = IDLE;
  logic [12:0] pins;
  logic        bwc, tick, fP, fOe, fN, sP, sOe, sN, lP, lN, rdN;
  logic        offAcc, tog;
  logic [39:0] hist = 40'h0;
  int          lowCnt, failCount, checked;

  initial forever #4 sys_clk = ~sys_clk;
  always_ff @(posedge sys_clk) hist <= {hist[38:0], lP};

  sltx_host_model host (.sys_clk(sys_clk), .stage(stage), .tick(tick),
    .byteWriteClock(bwc), .pins(pins));
  sltx_top dut (.sys_clk(sys_clk), .nrst(nrst), .byteWriteClock(bwc),
    .loadNowN(pins[12]), .loadNextN(pins[11]), .specialCharSelect(pins[10]),
    .sendViolation(pins[9]), .selfTestEnableN(pins[8]), .parallelByteIn(pins[7:0]),
    .opticalTxOff(optical_tx_off), .encoderModeRaw(raw), .encoderModeFloat(flt),
    .serialPairFirstPIn(fPin), .serialPairSecondPIn(sPin),
    .serialPairFirstP(fP), .serialPairFirstPOeN(fOe), .serialPairFirstN(fN),
    .serialPairSecondP(sP), .serialPairSecondPOeN(sOe), .serialPairSecondN(sN),
    .serialPairLoopbackP(lP), .serialPairLoopbackN(lN), .fifoReadStrobeN(rdN));

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Searching the recent bit history keeps the checks free of the pin filter's jitter.
  function automatic logic has(logic [9:0] code);
    has = 1'b0;
    for (int i = 0; i <= 30; i++) begin
      if (hist[i +: 10] === code) has = 1'b1;
    end
  endfunction : has

  task automatic slot(logic [12:0] v);
    do begin
      @(posedge sys_clk);
      #1;
    end while (tick !== 1'b1);
    stage = v;
  endtask : slot

  task automatic run(logic [12:0] v);
    slot(v);
    slot(IDLE);
    lowCnt = 0;
    offAcc = 1'b0;
    tog = 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      lowCnt += (rdN === 1'b0);
      offAcc |= fP | sP | ~fN | ~sN;
      tog |= (lP !== hist[0]);
    end
  endtask : run

  task automatic t_reset;
    repeat (4) @(posedge sys_clk);
    check("reset outputs", {fP, sP, lP, fN, sN, lN, fOe, sOe, rdN}, 16'h0039);
    nrst <= 1'b1;
  endtask : t_reset

  task automatic t_codes;
    run(IDLE);
    check("fill", has(10'h0FA) | has(10'h305), 1'b1);
    check("loop complement", lN, !lP);
    run(13'h09B5);
    check("data char", has(10'h2AA), 1'b1);
    check("strobe width", lowCnt, 6);
    run(13'h093C);
    check("data alphabet", has(10'h0E9), 1'b1);
    run(13'h0D3C);
    check("control alphabet", has(10'h0F9) | has(10'h306), 1'b1);
    slot(13'h1100);
    run(13'h19B5);
    check("load next", has(10'h2AA), 1'b1);
    run(13'h19B5);
    check("discard", has(10'h2AA), 1'b0);
    check("no strobe", lowCnt, 0);
    run(13'h0BB5);
    check("violation", has(10'h0F8), 1'b1);
    check("violation data", has(10'h2AA), 1'b0);
  endtask : t_codes

  task automatic t_modes;
    @(posedge sys_clk);
    raw <= 1'b1;
    run(13'h0B0F);
    check("raw word", has(10'h1E1), 1'b1);
    @(posedge sys_clk);
    raw <= 1'b0;
    optical_tx_off <= 1'b1;
    run(IDLE);
    check("optical off", offAcc, 1'b0);
    check("loop runs", tog, 1'b1);
    @(posedge sys_clk);
    optical_tx_off <= 1'b0;
    run(IDLE);
    check("optical on", offAcc, 1'b1);
    @(posedge sys_clk);
    flt <= 1'b1;
    run(IDLE);
    check("test pins input", {fOe, sOe}, 2'b11);
    @(posedge sys_clk);
    flt <= 1'b0;
    run(IDLE);
    check("pins driven", {fOe, sOe}, 2'b00);
  endtask : t_modes

  task automatic t_self_test;
    int n;
    run(13'h1800);
    check("alternating", has(10'h155), 1'b1);
    slot(13'h1A00);
    slot(13'h0800);
    repeat (28) @(posedge sys_clk);
    #1;
    check("violation wins", has(10'h0F8), 1'b1);
    check("sequence start", has(10'h274) | has(10'h18B), 1'b1);
    n = 0;
    while (rdN !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("loop length", (n > 2510 && n < 2540), 1'b1);
    n = 0;
    while (rdN === 1'b0 && n < 30) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("loop strobe", n, 10);
  endtask : t_self_test

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // The full sequence takes under 4000 cycles; twice that means a hang.
  initial begin
    #(8 * 8000);
    failCount++;
    wrap_up();
  end

  initial begin
    t_reset();
    t_codes();
    t_modes();
    t_self_test();
    wrap_up();
  end
endmodule : sltx_top_tb
`default_nettype wire
